// ---- rtl/uic_line_codec.sv ----
// line state coder for one side: full speed or low speed convention
// assumes pin levels are already synchronous
`timescale 1ns/1ps
module uic_line_codec import uic_pkg::*; (
  // convention
  input wire logic fullSpeed,
  // transmit
  input wire logic [1:0] txState,
  output logic txPos,
  output logic txNeg,
  // receive
  input wire logic rxPos,
  input wire logic rxNeg,
  output logic [1:0] rxState
);

  // ****************************************
  // encode and decode
  // ****************************************
  always_comb begin
    // invalid se1 is never driven; sent as se0
    case (txState)
      LINE_J: begin
        txPos = fullSpeed;
        txNeg = !fullSpeed;
      end
      LINE_K: begin
        txPos = !fullSpeed;
        txNeg = fullSpeed;
      end
      default: begin
        txPos = 1'b0;
        txNeg = 1'b0;
      end
    endcase
    case ({rxPos, rxNeg})
      2'b00: rxState = LINE_SE0;
      2'b11: rxState = LINE_SE1;
      2'b10: rxState = fullSpeed ? LINE_J : LINE_K;
      default: rxState = fullSpeed ? LINE_K : LINE_J;
    endcase
  end

endmodule

// ---- rtl/uic_pkg.sv ----
// constants, encodings and state types for the isolator port configuration block
// assumes one 40 MHz clock; data pins arrive synchronous to it, straps and supplies are synchronised
package uic_pkg;

  // ****************************************
  // clock and link timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int FS_BPS = 12_000_000;
  localparam int LS_BPS = 1_500_000;
  localparam int LOSS_BIT_TIMES = 32;
  // longest reaction to a supply loss, rounded down
  localparam int LOSS_FS_CYC = (LOSS_BIT_TIMES * CLK_HZ) / FS_BPS;
  localparam int LOSS_LS_CYC = (LOSS_BIT_TIMES * CLK_HZ) / LS_BPS;
  localparam int SYNC_STAGES = 2;
  localparam int SETTLE_CYC = 2;
  localparam int SETTLE_W = 2;

  // ****************************************
  // register port
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam int CTRL_SOFT_ATTACH = 0;
  localparam logic CTRL_SOFT_ATTACH_RST = 1'h1;
  localparam int ST_PULLDOWN_KEEP = 0;
  localparam int ST_UP_FULL = 1;
  localparam int ST_DN_FULL = 2;
  localparam int ST_SPEED_MISMATCH = 3;
  localparam int ST_CABLE_POWER = 4;
  localparam int ST_PERIPH_POWER = 5;
  localparam int ST_ATTACHED = 6;
  localparam int ST_STARTED = 7;
  localparam logic PULLDOWN_RST = 1'h1;

  // ****************************************
  // line states
  // ****************************************
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J = 2'h1;
  localparam logic [1:0] LINE_K = 2'h2;
  localparam logic [1:0] LINE_SE1 = 2'h3;

  typedef enum logic [1:0] {
    START_SETTLE,
    START_RUN
  } uic_start_t;

endpackage

// ---- rtl/uic_port_config.sv ----
// isolator port configuration and attach control, both sides
// assumes one clock, synchronous active-low reset, straps tied or slow
//
// What this block does
// - pull-down strap is read only when leaving reset, then ignored.
// - strap low at reset exit removes downstream pull-downs; high keeps them.
// - upstream speed select high gives full speed convention, low gives low speed.
// - downstream speed select high gives full speed convention, low gives low speed.
// - upstream pull-up powered only while attach enable is asserted.
// - attach off with both powered puts all data lines in high impedance.
// - downstream power loss drops pull-up and upstream drivers within 32 bit times.
// - upstream power loss floats downstream drivers within 32 bit times; start floating.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module uic_port_config import uic_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // straps and enables
  input wire logic pulldownKeepStrap,
  input wire logic upstreamSpeedSelect,
  input wire logic downstreamSpeedSelect,
  input wire logic attachEnable,
  // supply health
  input wire logic cableSideSupply,
  input wire logic peripheralSideSupply,
  // cable side drive requests and received state
  input wire logic cableDriveReq,
  input wire logic [1:0] cableDriveState,
  output logic [1:0] cableRxState,
  // cable side pins
  input wire logic cableSideDataPosIn,
  input wire logic cableSideDataNegIn,
  output logic cableSideDataPosOut,
  output logic cableSideDataNegOut,
  output logic cableSideDataOe,
  output logic cableFullSpeed,
  output logic cablePullup,
  // peripheral side drive requests and received state
  input wire logic periphDriveReq,
  input wire logic [1:0] periphDriveState,
  output logic [1:0] periphRxState,
  // peripheral side pins
  input wire logic peripheralSideDataPosIn,
  input wire logic peripheralSideDataNegIn,
  output logic peripheralSideDataPosOut,
  output logic peripheralSideDataNegOut,
  output logic peripheralSideDataOe,
  output logic periphFullSpeed,
  output logic periphPulldown,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData
);

  if (LOSS_FS_CYC < SYNC_STAGES + 1) begin : g_bad_timing
    $error("supply loss reaction cannot fit in 32 bit times");
  end

  // ****************************************
  // synchronisers
  // ****************************************
  logic [5:0] syncIn;
  logic [5:0] syncOut;
  logic strapSync;
  logic upFullSync;
  logic dnFullSync;
  logic attachSync;
  logic cablePowerSync;
  logic periphPowerSync;

  assign syncIn = {peripheralSideSupply, cableSideSupply, attachEnable,
                   downstreamSpeedSelect, upstreamSpeedSelect, pulldownKeepStrap};

  uic_sync #(
    .WIDTH(6),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .din(syncIn),
    .dout(syncOut)
  );

  assign strapSync = syncOut[0];
  assign upFullSync = syncOut[1];
  assign dnFullSync = syncOut[2];
  assign attachSync = syncOut[3];
  assign cablePowerSync = syncOut[4];
  assign periphPowerSync = syncOut[5];

  // speed conventions follow the synchronised selects
  assign cableFullSpeed = upFullSync;
  assign periphFullSpeed = dnFullSync;

  // ****************************************
  // start-up and strap capture
  // ****************************************
  uic_start_t startState;
  uic_start_t next_startState;
  logic [SETTLE_W-1:0] settleCnt;
  logic [SETTLE_W-1:0] next_settleCnt;
  logic next_periphPulldown;
  logic strapTake;

  always_comb begin
    next_startState = startState;
    next_settleCnt = settleCnt;
    next_periphPulldown = periphPulldown;
    strapTake = 1'b0;
    case (startState)
      START_SETTLE: begin
        if (settleCnt == SETTLE_W'(SETTLE_CYC)) begin
          strapTake = 1'b1;
          next_periphPulldown = strapSync;
          next_startState = START_RUN;
        end else begin
          next_settleCnt = settleCnt + SETTLE_W'(1);
        end
      end
      START_RUN: begin
        next_startState = START_RUN;
      end
      default: begin
        next_startState = START_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      startState <= START_SETTLE;
      settleCnt <= '0;
      periphPulldown <= PULLDOWN_RST;
    end else begin
      startState <= next_startState;
      settleCnt <= next_settleCnt;
      periphPulldown <= next_periphPulldown;
    end
  end

  // ****************************************
  // line coding
  // ****************************************
  logic cableTxPos;
  logic cableTxNeg;
  logic periphTxPos;
  logic periphTxNeg;
  logic [1:0] cableRxNow;
  logic [1:0] periphRxNow;

  uic_line_codec u_cable_codec (
    .fullSpeed(upFullSync),
    .txState(cableDriveState),
    .txPos(cableTxPos),
    .txNeg(cableTxNeg),
    .rxPos(cableSideDataPosIn),
    .rxNeg(cableSideDataNegIn),
    .rxState(cableRxNow)
  );

  uic_line_codec u_periph_codec (
    .fullSpeed(dnFullSync),
    .txState(periphDriveState),
    .txPos(periphTxPos),
    .txNeg(periphTxNeg),
    .rxPos(peripheralSideDataPosIn),
    .rxNeg(peripheralSideDataNegIn),
    .rxState(periphRxNow)
  );

  // ****************************************
  // attach, pull-up and driver control
  // ****************************************
  logic softAttach;
  logic attachOk;
  logic linkUp;
  logic started;
  logic next_cablePullup;
  logic next_cableOe;
  logic next_periphOe;
  logic next_cablePos;
  logic next_cableNeg;
  logic next_periphPos;
  logic next_periphNeg;
  logic [1:0] next_cableRx;
  logic [1:0] next_periphRx;

  assign started = (startState == START_RUN);
  assign attachOk = attachSync && softAttach;
  assign linkUp = attachOk && cablePowerSync && periphPowerSync;

  always_comb begin
    // pull-up powered only while attached and the far side lives
    next_cablePullup = linkUp;
    // drivers float when detached or either side unpowered
    next_cableOe = cableDriveReq && linkUp && started;
    next_periphOe = periphDriveReq && linkUp && started;
    next_cablePos = cableTxPos;
    next_cableNeg = cableTxNeg;
    next_periphPos = periphTxPos;
    next_periphNeg = periphTxNeg;
    next_cableRx = cableRxNow;
    next_periphRx = periphRxNow;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cablePullup <= 1'b0;
      cableSideDataOe <= 1'b0;
      peripheralSideDataOe <= 1'b0;
      cableSideDataPosOut <= 1'b0;
      cableSideDataNegOut <= 1'b0;
      peripheralSideDataPosOut <= 1'b0;
      peripheralSideDataNegOut <= 1'b0;
      cableRxState <= LINE_SE0;
      periphRxState <= LINE_SE0;
    end else begin
      cablePullup <= next_cablePullup;
      cableSideDataOe <= next_cableOe;
      peripheralSideDataOe <= next_periphOe;
      cableSideDataPosOut <= next_cablePos;
      cableSideDataNegOut <= next_cableNeg;
      peripheralSideDataPosOut <= next_periphPos;
      peripheralSideDataNegOut <= next_periphNeg;
      cableRxState <= next_cableRx;
      periphRxState <= next_periphRx;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  logic next_softAttach;
  logic [DATA_W-1:0] next_regRdData;
  logic [DATA_W-1:0] statusWord;

  always_comb begin
    statusWord = '0;
    statusWord[ST_PULLDOWN_KEEP] = periphPulldown;
    statusWord[ST_UP_FULL] = upFullSync;
    statusWord[ST_DN_FULL] = dnFullSync;
    statusWord[ST_SPEED_MISMATCH] = upFullSync ^ dnFullSync;
    statusWord[ST_CABLE_POWER] = cablePowerSync;
    statusWord[ST_PERIPH_POWER] = periphPowerSync;
    statusWord[ST_ATTACHED] = cablePullup;
    statusWord[ST_STARTED] = started;
    next_softAttach = softAttach;
    if (regWr && regAddr == REG_CTRL) begin
      next_softAttach = regWrData[CTRL_SOFT_ATTACH];
    end
    next_regRdData = '0;
    if (regRd) begin
      case (regAddr)
        REG_CTRL: next_regRdData[CTRL_SOFT_ATTACH] = softAttach;
        REG_STATUS: next_regRdData = statusWord;
        default: next_regRdData = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      softAttach <= CTRL_SOFT_ATTACH_RST;
      regRdData <= '0;
    end else begin
      softAttach <= next_softAttach;
      regRdData <= next_regRdData;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_detached;
    !attachSync [*2];
  endsequence

  sequence s_periph_lost;
    $fell(periphPowerSync);
  endsequence

  sequence s_cable_lost;
    $fell(cablePowerSync);
  endsequence

  chk_strap_capture: assert property (
    strapTake |=> periphPulldown == $past(strapSync))
    else $error("pull-down state differs from strap at reset exit");

  chk_strap_hold: assert property (
    started && $past(started) |-> $stable(periphPulldown))
    else $error("pull-down state changed after reset exit");

  chk_up_speed: assert property (
    $past(nrst) && $past(nrst, 2) |-> cableFullSpeed == $past(upstreamSpeedSelect, 2))
    else $error("upstream convention does not follow its select");

  chk_dn_speed: assert property (
    $past(nrst) && $past(nrst, 2) |-> periphFullSpeed == $past(downstreamSpeedSelect, 2))
    else $error("downstream convention does not follow its select");

  chk_pullup_attach: assert property (
    1'b1 |=> cablePullup == $past(attachOk && cablePowerSync && periphPowerSync))
    else $error("pull-up does not track attach enable");

  chk_detach_hiz: assert property (
    s_detached |-> !cableSideDataOe && !peripheralSideDataOe && !cablePullup)
    else $error("data lines driven while detached");

  chk_periph_loss: assert property (
    s_periph_lost |-> ##[1:2] (!cablePullup && !cableSideDataOe))
    else $error("upstream side not released after downstream power loss");

  chk_cable_loss: assert property (
    s_cable_lost |-> ##[1:2] !peripheralSideDataOe)
    else $error("downstream drivers not released after upstream power loss");

  chk_init_hiz: assert property (
    !started |-> !peripheralSideDataOe && !cableSideDataOe)
    else $error("drivers enabled before start-up completed");

endmodule

// ---- rtl/uic_sync.sv ----
// multi-bit level synchroniser, one chain per bit
// assumes levels only; no event crosses through it
`timescale 1ns/1ps
module uic_sync import uic_pkg::*; #(
  parameter int WIDTH = 1,
  parameter int STAGES = SYNC_STAGES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  if (STAGES < 2) begin : g_bad_stages
    $error("uic_sync needs at least two stages");
  end

  // ****************************************
  // one chain per bit
  // ****************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;
    always_comb begin
      next_chain = {chain[STAGES-2:0], din[i]};
    end
    always_ff @(posedge clock) begin
      if (!nrst) begin
        chain <= '0;
      end else begin
        chain <= next_chain;
      end
    end
    assign dout[i] = chain[STAGES-1];
  end

endmodule

// ---- testbench/uic_far_side.sv ----
// far side model: usb host on the cable, peripheral controller behind the block
// assumes pins resolve on the same clock as the block; no contention between drivers
`timescale 1ns/1ps
module uic_far_side (
  // clock
  input wire logic clock,
  // cable side
  input wire logic cablePos,
  input wire logic cableNeg,
  input wire logic cableOe,
  input wire logic cableFs,
  input wire logic cablePullup,
  input wire logic hostDrive,
  input wire logic [1:0] hostState,
  output logic cableWirePos,
  output logic cableWireNeg,
  // peripheral side
  input wire logic periphPos,
  input wire logic periphNeg,
  input wire logic periphOe,
  input wire logic periphFs,
  input wire logic periphPulldown,
  input wire logic ctrlDrive,
  input wire logic [1:0] ctrlState,
  output logic periphWirePos,
  output logic periphWireNeg
);
  logic [1:0] lastPeriph = 2'h0;

  // line code of one state; low speed swaps the pair
  function automatic logic [1:0] line_enc(input logic [1:0] st, input logic fs);
    logic [1:0] v;
    v = (st == 2'h1) ? 2'h2 : ((st == 2'h2) ? 2'h1 : 2'h0);
    return fs ? v : {v[0], v[1]};
  endfunction

  // cable: block, host, else pull-up against host pull-downs
  always_comb begin
    if (cableOe) begin
      {cableWirePos, cableWireNeg} = {cablePos, cableNeg};
    end else if (hostDrive) begin
      {cableWirePos, cableWireNeg} = line_enc(hostState, cableFs);
    end else begin
      {cableWirePos, cableWireNeg} = cablePullup ? (cableFs ? 2'h2 : 2'h1) : 2'h0;
    end
  end

  // peripheral: floating pair reads se0 with pull-downs kept, else the inverse of the last level
  always_comb begin
    if (periphOe) begin
      {periphWirePos, periphWireNeg} = {periphPos, periphNeg};
    end else if (ctrlDrive) begin
      {periphWirePos, periphWireNeg} = line_enc(ctrlState, periphFs);
    end else begin
      {periphWirePos, periphWireNeg} = periphPulldown ? 2'h0 : ~lastPeriph;
    end
  end

  // remember the last driven level only
  always_ff @(posedge clock) begin
    if (periphOe || ctrlDrive) begin
      lastPeriph <= {periphWirePos, periphWireNeg};
    end
  end
endmodule

// ---- testbench/uic_port_config_tb.sv ----
// self-checking bench for the isolator port configuration block
// assumes uic_pkg and the far side model compiled first
`timescale 1ns/1ps
module uic_port_config_tb import uic_pkg::*;;
  logic clock = 1'b0, nrst = 1'b0, strap = 1'b1, upSel = 1'b1, dnSel = 1'b1, attach = 1'b1;
  logic cSup = 1'b1, pSup = 1'b1, cReq = 1'b0, pReq = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic hostDrive = 1'b0, ctrlDrive = 1'b0;
  logic [1:0] cState = 2'h1, pState = 2'h1, hostState = 2'h1, ctrlState = 2'h1, cRx, pRx;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWrData = 32'h0, regRdData, rd;
  logic cPosO, cNegO, cOe, cFs, cPu, cPosI, cNegI, pPosO, pNegO, pOe, pFs, pPd, pPosI, pNegI;
  int failures = 0, cmpCount = 0;

  always #12.5 clock = ~clock;

  uic_port_config DUT (.clock(clock), .nrst(nrst), .pulldownKeepStrap(strap),
    .upstreamSpeedSelect(upSel), .downstreamSpeedSelect(dnSel), .attachEnable(attach),
    .cableSideSupply(cSup), .peripheralSideSupply(pSup), .cableDriveReq(cReq),
    .cableDriveState(cState), .cableRxState(cRx), .cableSideDataPosIn(cPosI),
    .cableSideDataNegIn(cNegI), .cableSideDataPosOut(cPosO), .cableSideDataNegOut(cNegO),
    .cableSideDataOe(cOe), .cableFullSpeed(cFs), .cablePullup(cPu), .periphDriveReq(pReq),
    .periphDriveState(pState), .periphRxState(pRx), .peripheralSideDataPosIn(pPosI),
    .peripheralSideDataNegIn(pNegI), .peripheralSideDataPosOut(pPosO),
    .peripheralSideDataNegOut(pNegO), .peripheralSideDataOe(pOe), .periphFullSpeed(pFs),
    .periphPulldown(pPd), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData));

  uic_far_side far (.clock(clock), .cablePos(cPosO), .cableNeg(cNegO), .cableOe(cOe),
    .cableFs(cFs), .cablePullup(cPu), .hostDrive(hostDrive), .hostState(hostState),
    .cableWirePos(cPosI), .cableWireNeg(cNegI), .periphPos(pPosO), .periphNeg(pNegO),
    .periphOe(pOe), .periphFs(pFs), .periphPulldown(pPd), .ctrlDrive(ctrlDrive),
    .ctrlState(ctrlState), .periphWirePos(pPosI), .periphWireNeg(pNegI));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_check(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    d = regRdData;
  endtask

  task automatic do_reset(input logic s, input logic downstream_speed_select);
    @(posedge clock);
    nrst <= 1'b0;
    strap <= s;
    upSel <= downstream_speed_select;
    dnSel <= downstream_speed_select;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    wait_check(1);
    check(32'({cOe, pOe, cPu}), 32'h0, "drivers and pull-up at start");
    wait_check(6);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_strap;
    do_reset(1'b0, 1'b1);
    check(32'(pPd), 32'h0, "pull-downs removed");
    @(posedge clock);
    strap <= 1'b1;
    wait_check(5);
    check(32'(pPd), 32'h0, "late strap high");
    do_reset(1'b1, 1'b1);
    check(32'(pPd), 32'h1, "pull-downs kept");
    @(posedge clock);
    strap <= 1'b0;
    wait_check(5);
    check(32'(pPd), 32'h1, "late strap low");
    $display("test strap done");
  endtask

  task automatic t_speed;
    logic [1:0] fsTab [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
    logic [1:0] exp;
    for (int s = 0; s < 2; s++) begin
      do_reset(1'b1, s[0]);
      check(32'(cFs), 32'(s[0]), "cable speed");
      check(32'(pFs), 32'(s[0]), "periph speed");
      check(32'(cRx), 32'(LINE_J), "cable idle");
      reg_read(REG_STATUS, rd);
      check(rd, 32'({4'hf, 1'b0, s[0], s[0], 1'b1}), "status word");
      for (int i = 0; i < 4; i++) begin
        exp = s[0] ? fsTab[i] : {fsTab[i][0], fsTab[i][1]};
        @(posedge clock);
        cReq <= 1'b1;
        pReq <= 1'b1;
        cState <= 2'(i);
        pState <= 2'(i);
        wait_check(1);
        check(32'({cOe, cPosO, cNegO}), 32'({1'b1, exp}), "cable drive");
        check(32'({pOe, pPosO, pNegO}), 32'({1'b1, exp}), "periph drive");
      end
      @(posedge clock);
      pReq <= 1'b0;
      ctrlDrive <= 1'b1;
      ctrlState <= LINE_K;
      wait_check(3);
      check(32'(pRx), 32'(LINE_K), "periph receive");
      @(posedge clock);
      ctrlDrive <= 1'b0;
      cReq <= 1'b0;
    end
    $display("test speed done");
  endtask

  task automatic t_attach;
    reg_read(REG_CTRL, rd);
    check(32'(rd[0]), 32'(CTRL_SOFT_ATTACH_RST), "ctrl reset value");
    @(negedge clock);
    check(regRdData, 32'h0, "read data one cycle");
    @(posedge clock);
    attach <= 1'b0;
    cReq <= 1'b1;
    pReq <= 1'b1;
    wait_check(4);
    check(32'({cPu, cOe, pOe}), 32'h0, "detached");
    check(32'(cRx), 32'(LINE_SE0), "cable lines released");
    @(posedge clock);
    attach <= 1'b1;
    wait_check(4);
    check(32'({cPu, cOe, pOe}), 32'h7, "attached");
    reg_write(REG_CTRL, 32'h0);
    wait_check(4);
    check(32'(cPu), 32'h0, "soft detach");
    reg_write(REG_CTRL, 32'h1);
    reg_write(4'h8, 32'h0);
    reg_read(4'h8, rd);
    check(rd, 32'h0, "unmapped read");
    wait_check(4);
    check(32'(cPu), 32'h1, "soft attach");
    $display("test attach done");
  endtask

  task automatic t_supply;
    @(posedge clock);
    pSup <= 1'b0;
    wait_check(4);
    check(32'({cPu, cOe}), 32'h0, "periph power loss");
    @(posedge clock);
    pSup <= 1'b1;
    cSup <= 1'b0;
    wait_check(4);
    check(32'(pOe), 32'h0, "cable power loss");
    @(posedge clock);
    cSup <= 1'b1;
    cReq <= 1'b0;
    pReq <= 1'b0;
    $display("test supply done");
  endtask

  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    report_and_stop;
  end

  initial begin
    t_strap;
    t_speed;
    t_attach;
    t_supply;
    report_and_stop;
  end
endmodule
